// file: include/sac_pkg.sv
package sac_pkg;
    // bus clock rate and derived bus-clock counts
    localparam int CLOCK_MHZ = 25;
    localparam logic [1:0] SYNC_BUS_CYCLES = 2'h3;
    // converter clock counts per phase
    localparam logic [5:0] START_CONVERTER_CLOCK = 6'h02;
    localparam logic [5:0] SAMPLE_SHORT_CONVERTER_CLOCK = 6'h04;
    localparam logic [5:0] SAMPLE_LONG_CONVERTER_CLOCK = 6'h18;
    localparam logic [3:0] MSB_INDEX = 4'h9;
    // worst-case conversion budgets in converter clocks
    localparam logic [5:0] BUDGET_8S_FIRST = 6'h12;
    localparam logic [5:0] BUDGET_8S_NEXT = 6'h10;
    localparam logic [5:0] BUDGET_8L_FIRST = 6'h26;
    localparam logic [5:0] BUDGET_8L_NEXT = 6'h24;
    localparam logic [5:0] BUDGET_10S_FIRST = 6'h15;
    localparam logic [5:0] BUDGET_10S_NEXT = 6'h13;
    localparam logic [5:0] BUDGET_10L_FIRST = 6'h29;
    localparam logic [5:0] BUDGET_10L_NEXT = 6'h27;
    // field codes
    localparam logic [4:0] CHANNEL_OFF = 5'h1F;
    localparam logic [1:0] MODE_8BIT = 2'h0;
    localparam logic [1:0] DIV_BY_1 = 2'h0;
    localparam logic [1:0] DIV_BY_2 = 2'h1;
    localparam logic [1:0] DIV_BY_4 = 2'h2;
    localparam logic [1:0] DIV_BY_8 = 2'h3;
    // reset values, trial start code and full-scale codes
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [4:0] CHANNEL_RESET = 5'h1F;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [1:0] DIVIDE_RESET = 2'h0;
    localparam logic [9:0] TRIAL_MSB = 10'h200;
    localparam logic [7:0] FULL_SCALE_8 = 8'hFF;
    localparam logic [9:0] FULL_SCALE_10 = 10'h3FF;

    typedef enum logic [2:0] {
        st_idle, st_sync, st_start, st_sample, st_convert, st_xfer
    } sac_state_t;
endpackage : sac_pkg

// file: include/sac_clk_if.sv
`timescale 1ns/100ps
interface sac_clk_if;
    logic run;
    logic async_en;
    logic bus_sel;
    logic [1:0] divide;
    logic async_tick;
    logic alt_tick;
    logic converter_clock_tick;

    modport ctrl (output run, async_en, bus_sel, divide, async_tick, alt_tick,
                  input converter_clock_tick);
    modport div (input run, async_en, bus_sel, divide, async_tick, alt_tick,
                 output converter_clock_tick);
endinterface : sac_clk_if

// file: verilog/sac_clock_divider.sv
`timescale 1ns/100ps
module sac_clock_divider (
    input wire logic clock_in,
    input wire logic rstn_in,
    sac_clk_if.div clk_if
);
    logic [2:0] div_count;
    logic [2:0] div_limit;
    logic src_tick;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    // source selection: async wins, else bus clock or alternate
    assign src_tick = clk_if.async_en ? clk_if.async_tick :
                      (clk_if.bus_sel ? 1'b1 : clk_if.alt_tick);

    // divide ratio from the two-bit field
    always_comb begin
        case (clk_if.divide)
            sac_pkg::DIV_BY_1: div_limit = 3'h0;
            sac_pkg::DIV_BY_2: div_limit = 3'h1;
            sac_pkg::DIV_BY_4: div_limit = 3'h3;
            default: div_limit = 3'h7;
        endcase
    end

    // divider counter, held cleared while the converter is off
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_count <= 3'h0;
        end else if (!clk_if.run) begin
            div_count <= 3'h0;
        end else if (src_tick) begin
            div_count <= (div_count == div_limit) ? 3'h0 : div_count + 3'h1;
        end
    end

    assign clk_if.converter_clock_tick = clk_if.run & src_tick & (div_count == div_limit);

    property p_async_source;
        clk_if.async_en && !clk_if.async_tick |-> !clk_if.converter_clock_tick;
    endproperty
    a_async_source: assert property (p_async_source)
        else $error("converter clock ticked without async source tick");

    property p_bus_div1;
        clk_if.run && !clk_if.async_en && clk_if.bus_sel
            && clk_if.divide == sac_pkg::DIV_BY_1 |-> clk_if.converter_clock_tick;
    endproperty
    a_bus_div1: assert property (p_bus_div1)
        else $error("bus clock divide by one missed a tick");

    property p_div8_gap;
        clk_if.converter_clock_tick && $stable(clk_if.divide) && clk_if.divide == sac_pkg::DIV_BY_8
            && !clk_if.async_en && clk_if.bus_sel
            |=> !clk_if.converter_clock_tick [*7];
    endproperty
    a_div8_gap: assert property (p_div8_gap)
        else $error("divide by eight produced ticks too close");

    c_div8: cover property (clk_if.converter_clock_tick && clk_if.divide == sac_pkg::DIV_BY_8);
endmodule : sac_clock_divider

// file: verilog/sac_conversion_control.sv
`timescale 1ns/100ps
module sac_conversion_control (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic status_write_in,
    input wire logic [4:0] channel_select_in,
    input wire logic continuous_convert_in,
    input wire logic interrupt_enable_in,
    input wire logic clock_config_write_in,
    input wire logic async_clock_enable_in,
    input wire logic low_power_config_in,
    input wire logic [1:0] clock_divide_in,
    input wire logic long_sample_in,
    input wire logic input_clock_select_in,
    input wire logic [1:0] mode_in,
    input wire logic result_high_read_in,
    input wire logic result_low_read_in,
    input wire logic stop_mode_in,
    input wire logic comparator_in,
    input wire logic async_clock_tick_in,
    input wire logic alt_clock_tick_in,
    output logic [7:0] result_high_out,
    output logic [7:0] result_low_out,
    output logic conversion_complete_out,
    output logic interrupt_request_out,
    output logic converting_out,
    output logic [4:0] channel_select_out,
    output logic sampling_out,
    output logic [9:0] sar_trial_out,
    output logic async_clock_run_out,
    output logic async_low_rate_out,
    output logic analog_power_out
);
    sac_clk_if clk_if ();

    sac_pkg::sac_state_t state;
    logic [4:0] channel;
    logic continuous;
    logic irq_enable;
    logic async_en;
    logic low_power;
    logic [1:0] divide;
    logic long_sample;
    logic bus_sel;
    logic [1:0] mode;
    logic [5:0] phase_count;
    logic [3:0] bit_index;
    logic [9:0] trial;
    logic [9:0] next_trial;
    logic high_read_pending;
    logic conversion_complete;
    logic irq;
    logic [1:0] async_sync;
    logic [1:0] alt_sync;
    logic async_last;
    logic alt_last;
    logic abort;
    logic start_req;
    logic tick;
    logic mode8;
    logic blocked;
    logic xfer;
    logic [5:0] sample_len;
    logic [8:0] round_sum;
    logic [7:0] rounded;

    // clock source pins cross in through two flops, then edge detect
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            async_sync <= 2'h0;
            alt_sync <= 2'h0;
            async_last <= 1'b0;
            alt_last <= 1'b0;
        end else begin
            async_sync <= {async_sync[0], async_clock_tick_in};
            alt_sync <= {alt_sync[0], alt_clock_tick_in};
            async_last <= async_sync[1];
            alt_last <= alt_sync[1];
        end
    end

    // abort and start decode; only register writes start work
    assign abort = status_write_in | clock_config_write_in
                   | (stop_mode_in & ~async_en);
    assign start_req = status_write_in & (channel_select_in != sac_pkg::CHANNEL_OFF);
    assign tick = clk_if.converter_clock_tick;
    assign mode8 = (mode == sac_pkg::MODE_8BIT);
    assign blocked = ~mode8 & high_read_pending;
    assign xfer = (state == sac_pkg::st_xfer) & tick & ~abort;
    assign sample_len = long_sample ? sac_pkg::SAMPLE_LONG_CONVERTER_CLOCK
                                    : sac_pkg::SAMPLE_SHORT_CONVERTER_CLOCK;

    // clock divider hookup; runs only past the bus-clock sync phase
    assign clk_if.run = (state != sac_pkg::st_idle) & (state != sac_pkg::st_sync) & ~abort;
    assign clk_if.async_en = async_en;
    assign clk_if.bus_sel = input_clock_select_in ? 1'b1 : bus_sel;
    assign clk_if.divide = divide;
    assign clk_if.async_tick = async_sync[1] & ~async_last;
    assign clk_if.alt_tick = alt_sync[1] & ~alt_last;

    sac_clock_divider u_divider (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .clk_if(clk_if)
    );

    // status-control register fields
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            channel <= sac_pkg::CHANNEL_RESET;
            continuous <= 1'b0;
            irq_enable <= 1'b0;
        end else if (status_write_in) begin
            channel <= channel_select_in;
            continuous <= continuous_convert_in;
            irq_enable <= interrupt_enable_in;
        end
    end

    // clock configuration register fields
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            async_en <= 1'b0;
            low_power <= 1'b0;
            divide <= sac_pkg::DIVIDE_RESET;
            long_sample <= 1'b0;
            bus_sel <= 1'b0;
            mode <= sac_pkg::MODE_RESET;
        end else if (clock_config_write_in) begin
            async_en <= async_clock_enable_in;
            low_power <= low_power_config_in;
            divide <= clock_divide_in;
            long_sample <= long_sample_in;
            bus_sel <= input_clock_select_in;
            mode <= mode_in;
        end
    end

    // next trial word: keep or drop the current bit, try the next lower
    always_comb begin
        next_trial = trial;
        if (!comparator_in && bit_index <= sac_pkg::MSB_INDEX) begin
            next_trial[bit_index] = 1'b0;
        end
        if (bit_index != 4'h0) begin
            next_trial[bit_index - 4'h1] = 1'b1;
        end
    end

    // conversion sequencer
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= sac_pkg::st_idle;
            phase_count <= 6'h00;
            bit_index <= 4'h0;
            trial <= 10'h000;
        end else if (abort) begin
            state <= start_req ? sac_pkg::st_sync : sac_pkg::st_idle;
            phase_count <= 6'h00;
        end else begin
            case (state)
                sac_pkg::st_idle: begin
                    phase_count <= 6'h00;
                end
                sac_pkg::st_sync: begin
                    if (phase_count[1:0] == sac_pkg::SYNC_BUS_CYCLES - 2'h1) begin
                        state <= sac_pkg::st_start;
                        phase_count <= 6'h00;
                    end else begin
                        phase_count <= phase_count + 6'h01;
                    end
                end
                sac_pkg::st_start: begin
                    if (tick && phase_count == sac_pkg::START_CONVERTER_CLOCK - 6'h01) begin
                        state <= sac_pkg::st_sample;
                        phase_count <= 6'h00;
                    end else if (tick) begin
                        phase_count <= phase_count + 6'h01;
                    end
                end
                sac_pkg::st_sample: begin
                    if (tick && phase_count == sample_len - 6'h01) begin
                        state <= sac_pkg::st_convert;
                        phase_count <= 6'h00;
                        bit_index <= sac_pkg::MSB_INDEX;
                        trial <= sac_pkg::TRIAL_MSB;
                    end else if (tick) begin
                        phase_count <= phase_count + 6'h01;
                    end
                end
                sac_pkg::st_convert: begin
                    if (tick) begin
                        trial <= next_trial;
                        bit_index <= bit_index - 4'h1;
                        if (bit_index == 4'h0) begin
                            state <= sac_pkg::st_xfer;
                        end
                    end
                end
                sac_pkg::st_xfer: begin
                    if (tick) begin
                        phase_count <= 6'h00;
                        if (blocked || continuous) begin
                            state <= sac_pkg::st_sample;
                        end else begin
                            state <= sac_pkg::st_idle;
                        end
                    end
                end
                default: begin
                    state <= sac_pkg::st_idle;
                end
            endcase
        end
    end

    // round to 8 bits, saturating at full scale
    assign round_sum = {1'b0, trial[9:2]} + {8'h00, trial[1]};
    assign rounded = round_sum[8] ? sac_pkg::FULL_SCALE_8 : round_sum[7:0];

    // result registers, only touched by a successful transfer
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            result_high_out <= sac_pkg::RESULT_RESET;
            result_low_out <= sac_pkg::RESULT_RESET;
        end else if (xfer && !blocked) begin
            if (mode8) begin
                result_high_out <= sac_pkg::RESULT_RESET;
                result_low_out <= rounded;
            end else begin
                result_high_out <= {6'h00, trial[9:8]};
                result_low_out <= trial[7:0];
            end
        end
    end

    // split-read tracker for the 10-bit result pair
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            high_read_pending <= 1'b0;
        end else if (result_high_read_in && !mode8) begin
            high_read_pending <= 1'b1;
        end else if (result_low_read_in) begin
            high_read_pending <= 1'b0;
        end
    end

    // complete flag and interrupt; a set beats a same-cycle low read, a same-cycle status write aborts the set and clears
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            conversion_complete <= 1'b0;
            irq <= 1'b0;
        end else if (xfer && !blocked) begin
            conversion_complete <= 1'b1;
            irq <= irq_enable;
        end else if (status_write_in || result_low_read_in) begin
            conversion_complete <= 1'b0;
            irq <= 1'b0;
        end
    end

    assign conversion_complete_out = conversion_complete;
    assign interrupt_request_out = irq;
    assign converting_out = (state != sac_pkg::st_idle);
    assign channel_select_out = channel;
    assign sampling_out = (state == sac_pkg::st_sample);
    assign sar_trial_out = trial;
    assign analog_power_out = (state != sac_pkg::st_idle) & ~abort;
    assign async_clock_run_out = async_en & (state != sac_pkg::st_idle) & ~abort;
    assign async_low_rate_out = low_power;

    // helper: converter clocks spent on the current conversion
    logic [5:0] conv_ticks;
    logic conv_first;
    logic [5:0] budget;
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            conv_ticks <= 6'h00;
            conv_first <= 1'b0;
        end else if (state == sac_pkg::st_sync) begin
            conv_ticks <= 6'h00;
            conv_first <= 1'b1;
        end else if (xfer) begin
            conv_ticks <= 6'h00;
            conv_first <= 1'b0;
        end else if (tick) begin
            conv_ticks <= conv_ticks + 6'h01;
        end
    end
    always_comb begin
        case ({mode8, long_sample, conv_first})
            3'h0: budget = sac_pkg::BUDGET_10S_NEXT;
            3'h1: budget = sac_pkg::BUDGET_10S_FIRST;
            3'h2: budget = sac_pkg::BUDGET_10L_NEXT;
            3'h3: budget = sac_pkg::BUDGET_10L_FIRST;
            3'h4: budget = sac_pkg::BUDGET_8S_NEXT;
            3'h5: budget = sac_pkg::BUDGET_8S_FIRST;
            3'h6: budget = sac_pkg::BUDGET_8L_NEXT;
            default: budget = sac_pkg::BUDGET_8L_FIRST;
        endcase
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rstn_in);

    property p_budget;
        xfer |-> conv_ticks + 6'h01 <= budget;
    endproperty
    a_budget: assert property (p_budget)
        else $error("conversion exceeded its clock budget");

    property p_start;
        start_req |=> state == sac_pkg::st_sync ##3 state == sac_pkg::st_start;
    endproperty
    a_start: assert property (p_start)
        else $error("start write did not begin a conversion");

    property p_off;
        status_write_in && channel_select_in == sac_pkg::CHANNEL_OFF |=> !converting_out;
    endproperty
    a_off: assert property (p_off)
        else $error("all-ones channel left converter running");

    property p_abort_power;
        abort |-> !analog_power_out && !async_clock_run_out;
    endproperty
    a_abort_power: assert property (p_abort_power)
        else $error("abort did not drop power at once");

    property p_complete;
        xfer && !blocked && !status_write_in |=> conversion_complete && (irq == $past(irq_enable));
    endproperty
    a_complete: assert property (p_complete)
        else $error("transfer did not set completion correctly");

    property p_blocked;
        xfer && blocked |=> $stable(result_low_out) && $stable(result_high_out)
            && state == sac_pkg::st_sample;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("blocked transfer overwrote result or stopped");

    property p_full8;
        xfer && !blocked && mode8 && trial == sac_pkg::FULL_SCALE_10
            |=> result_low_out == sac_pkg::FULL_SCALE_8 && result_high_out == 8'h00;
    endproperty
    a_full8: assert property (p_full8)
        else $error("8-bit full scale not rounded to FF");

    property p_abort_keep;
        abort && !xfer |=> $stable(result_low_out) && $stable(result_high_out);
    endproperty
    a_abort_keep: assert property (p_abort_keep)
        else $error("abort altered result registers");

    c_single: cover property (xfer && !blocked && !continuous);
    c_cont: cover property (xfer && continuous ##1 state == sac_pkg::st_sample);
    c_block: cover property (xfer && blocked);
    c_mode8: cover property (xfer && mode8 && long_sample);
endmodule : sac_conversion_control

// file: verification/sac_analog_model.sv
`timescale 1ns/100ps
// analog channel levels, comparator and free-running clock sources
module sac_analog_model (
    input wire logic clock_in,
    input wire logic [31:0][9:0] level_in,
    input wire logic [4:0] channel_in,
    input wire logic [9:0] trial_in,
    output logic comparator_out,
    output logic async_tick_out,
    output logic alt_tick_out
);
    logic [3:0] div_count;
    // input at or above the trial code answers high, only the selected channel counts
    assign comparator_out = level_in[channel_in] >= trial_in;
    // sources start low so ticks are never unknown
    initial begin
        div_count = 4'h0;
        async_tick_out = 1'b0;
        alt_tick_out = 1'b0;
    end
    // alternate source ticks every 2 bus cycles, dedicated source every 32
    always @(posedge clock_in) begin
        alt_tick_out <= ~alt_tick_out;
        div_count <= div_count + 4'h1;
        if (div_count == 4'h0) async_tick_out <= ~async_tick_out;
    end
endmodule : sac_analog_model

// file: verification/sac_conversion_control_tb.sv
`timescale 1ns/100ps
module sac_conversion_control_tb;
    logic clock_in, rstn_in, status_write_in, continuous_convert_in, interrupt_enable_in;
    logic clock_config_write_in, async_clock_enable_in, low_power_config_in, long_sample_in;
    logic input_clock_select_in, result_high_read_in, result_low_read_in, stop_mode_in;
    logic comparator_in, async_clock_tick_in, alt_clock_tick_in, conversion_complete_out;
    logic interrupt_request_out, converting_out, sampling_out, async_clock_run_out;
    logic async_low_rate_out, analog_power_out, ie;
    logic [4:0] channel_select_in, channel_select_out, ch;
    logic [1:0] clock_divide_in, mode_in;
    logic [7:0] result_high_out, result_low_out, cfg;
    logic [9:0] sar_trial_out, v;
    logic [31:0][9:0] level;
    int errors = 0, tests_run = 0, cycles = 0, seed = 10, n, bound;

    sac_conversion_control dut_u (.clock_in, .rstn_in, .status_write_in, .channel_select_in,
        .continuous_convert_in, .interrupt_enable_in, .clock_config_write_in,
        .async_clock_enable_in, .low_power_config_in, .clock_divide_in, .long_sample_in,
        .input_clock_select_in, .mode_in, .result_high_read_in, .result_low_read_in,
        .stop_mode_in, .comparator_in, .async_clock_tick_in, .alt_clock_tick_in,
        .result_high_out, .result_low_out, .conversion_complete_out, .interrupt_request_out,
        .converting_out, .channel_select_out, .sampling_out, .sar_trial_out,
        .async_clock_run_out, .async_low_rate_out, .analog_power_out);
    sac_analog_model model_u (.clock_in, .level_in(level), .channel_in(channel_select_out),
        .trial_in(sar_trial_out), .comparator_out(comparator_in),
        .async_tick_out(async_clock_tick_in), .alt_tick_out(alt_clock_tick_in));

    // bus clock and hang guard
    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic pulse_status(input logic [4:0] c, input logic cont, input logic en);
        @(posedge clock_in);
        status_write_in <= 1'b1;
        channel_select_in <= c;
        continuous_convert_in <= cont;
        interrupt_enable_in <= en;
        @(posedge clock_in);
        status_write_in <= 1'b0;
    endtask : pulse_status
    // cfg packs async, low power, divide, long sample, bus select, mode
    task automatic pulse_config(input logic [7:0] c);
        @(posedge clock_in);
        clock_config_write_in <= 1'b1;
        {async_clock_enable_in, low_power_config_in, clock_divide_in, long_sample_in,
            input_clock_select_in, mode_in} <= c;
        @(posedge clock_in);
        clock_config_write_in <= 1'b0;
    endtask : pulse_config
    task automatic pulse_read(input logic high);
        @(posedge clock_in);
        if (high) result_high_read_in <= 1'b1;
        else result_low_read_in <= 1'b1;
        @(posedge clock_in);
        result_high_read_in <= 1'b0;
        result_low_read_in <= 1'b0;
    endtask : pulse_read
    // count settled cycles until the complete flag shows, up to a limit
    task automatic wait_done(input int limit);
        n = 0;
        do begin
            @(negedge clock_in);
            n++;
        end while (conversion_complete_out !== 1'b1 && n < limit);
    endtask : wait_done
    task automatic set_stop(input logic s);
        @(posedge clock_in);
        stop_mode_in <= s;
    endtask : set_stop
    function automatic logic [7:0] exp_low(input logic [1:0] m, input logic [9:0] x);
        if (m != 2'h0) return x[7:0];
        return (x[9:2] == 8'hFF) ? 8'hFF : x[9:2] + {7'h0, x[1]};
    endfunction : exp_low
    // worst-case converter clocks of one conversion
    function automatic int budget(input logic [1:0] m, input logic ls, input logic first);
        return (m == 2'h0 ? 18 : 21) + (ls ? 20 : 0) - (first ? 0 : 2);
    endfunction : budget

    // main sequence
    initial begin
        {rstn_in, status_write_in, continuous_convert_in, interrupt_enable_in} = 4'h0;
        {clock_config_write_in, async_clock_enable_in, low_power_config_in} = 3'h0;
        {long_sample_in, input_clock_select_in, result_high_read_in} = 3'h0;
        {result_low_read_in, stop_mode_in, clock_divide_in, mode_in} = 6'h00;
        channel_select_in = 5'h1F;
        level = '0;
        repeat (5) @(posedge clock_in);
        rstn_in <= 1'b1;
        @(negedge clock_in);
        check("reset channel", 10'h01F, channel_select_out);
        check("reset low", 10'h000, result_low_out);
        // random single conversions, first two at the reference limits
        for (int i = 0; i < 12; i++) begin
            cfg = 8'($random(seed)) & 8'h7F;
            ch = 5'($unsigned($random(seed)) % 31);
            ie = 1'($random(seed));
            for (int k = 0; k < 32; k++) level[k] = 10'($random(seed));
            v = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($random(seed));
            level[ch] = v;
            bound = (budget(cfg[1:0], cfg[3], 1'b1) + 1) * (1 << cfg[5:4]) * (cfg[2] ? 1 : 2) + 8;
            pulse_config(cfg);
            pulse_status(ch, 1'b0, ie);
            wait_done(bound);
            check("in time", 10'h001, 10'(n < bound));
            check("low", 10'(exp_low(cfg[1:0], v)), 10'(result_low_out));
            check("high", cfg[1:0] == 2'h0 ? 10'h0 : 10'(v[9:8]), 10'(result_high_out));
            check("irq", 10'(ie), 10'(interrupt_request_out));
            check("trial", v, sar_trial_out);
            pulse_read(1'b1);
            pulse_read(1'b0);
            check("single idle", 10'h000, 10'(converting_out));
        end
        // high read without low read drops the transfer and restarts
        pulse_config(8'h05);
        level[4] = 10'h2A5;
        pulse_status(5'h04, 1'b0, 1'b0);
        pulse_read(1'b1);
        repeat (40) @(negedge clock_in);
        check("blocked flag", 10'h000, 10'(conversion_complete_out));
        check("restart", 10'h001, 10'(converting_out));
        pulse_read(1'b0);
        wait_done(30);
        check("after block", 10'h0A5, 10'(result_low_out));
        // continuous run at divide by two, then module off
        pulse_config(8'h15);
        level[2] = 10'h155;
        pulse_status(5'h02, 1'b1, 1'b1);
        wait_done(52);
        check("cont first", 10'h055, 10'(result_low_out));
        pulse_read(1'b0);
        level[2] = 10'h0AA;
        wait_done(48);
        check("cont next", 10'h0AA, 10'(result_low_out));
        pulse_status(5'h1F, 1'b0, 1'b0);
        repeat (2) @(negedge clock_in);
        check("off idle", 10'h000, 10'(converting_out));
        // clock write and stop without dedicated clock abort, results kept
        level[2] = 10'h3FF;
        for (int k = 0; k < 2; k++) begin
            pulse_status(5'h02, 1'b0, 1'b0);
            repeat (10) @(negedge clock_in);
            check("sampling", 10'h001, 10'(sampling_out));
            if (k == 0) pulse_config(8'h15);
            else set_stop(1'b1);
            repeat (2) @(negedge clock_in);
            check("aborted", 10'h000, 10'(converting_out));
            check("power off", 10'h000, 10'(analog_power_out));
            check("kept", 10'h0AA, 10'(result_low_out));
            set_stop(1'b0);
        end
        // dedicated clock keeps converting in stop, slow range asked for
        pulse_config(8'hC1);
        level[7] = 10'h123;
        pulse_status(5'h07, 1'b0, 1'b0);
        set_stop(1'b1);
        @(negedge clock_in);
        check("async run", 10'h001, 10'(async_clock_run_out));
        check("low rate", 10'h001, 10'(async_low_rate_out));
        wait_done(2000);
        check("stop result", 10'h023, 10'(result_low_out));
        check("stop high", 10'h001, 10'(result_high_out));
        set_stop(1'b0);
        repeat (4) @(negedge clock_in);
        check("async off", 10'h000, 10'(async_clock_run_out));
        // reset clears results
        @(posedge clock_in);
        rstn_in <= 1'b0;
        @(negedge clock_in);
        check("reset clear", 10'h000, 10'(result_low_out));
        check("reset idle", 10'h000, 10'(analog_power_out));
        tally_and_finish();
    end
endmodule : sac_conversion_control_tb
